// >>> wpg_pkg.sv
/*
  Shared constants and carrier types for the EEPROM write-protect gate.
  Assumes a two-wire byte engine outside that decodes control bytes and
  array write addresses and reports them on the serial-clock side.
*/
package wpg_pkg;

  // ==========================================================
  // Control byte layout
  localparam int unsigned NIB_HI = 7;
  localparam int unsigned NIB_LO = 4;
  localparam int unsigned RW_BIT = 0;
  localparam logic [3:0] NIB_ARRAY = 4'h_A;
  localparam logic [3:0] NIB_FLAG = 4'h_6;
  // Low nibble without R/W bit, for reversible set/query and clear
  localparam logic [2:0] SUB_REV_SET = 3'h_1;
  localparam logic [2:0] SUB_REV_CLR = 3'h_3;

  // ==========================================================
  // Array split: software protection covers the lower half only
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned ADDR_HALF_BIT = 7;

  // ==========================================================
  // Synchroniser depth and reset values
  localparam int unsigned SYNC_STAGES = 3;
  localparam logic RST_FLAG = 1'b0;

  typedef enum {
    WPG_LOAD,
    WPG_READY
  } wpg_state_t;

  typedef struct packed {
    logic perm;
    logic rev;
  } wpg_flags_t;

  typedef struct packed {
    logic valid;
    logic [7:0] ctl;
  } wpg_ctl_t;

  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
  } wpg_wr_t;

endpackage

// >>> wpg_gate.sv
/*
  Write-protect decision logic: nonvolatile flag handling in the clk_i
  domain, acknowledge and store decisions in the serial-clock domain.
  Assumes a byte engine that presents each control byte and each array
  write address as one-cycle strobes on link_clk_i, and a nonvolatile
  cell store that presents the saved flags once reset is released.
*/
`timescale 1ns/100ps
module wpg_gate
  import wpg_pkg::*;
(
  // Core clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Nonvolatile cells: saved value and write-back
  input wire wpg_flags_t nv_flags_i,
  output wpg_flags_t nv_flags_o,
  output logic nv_wr_o,
  // Core status
  output logic ready_o,
  output wpg_flags_t flags_o,
  // Link side, on the serial clock
  input wire logic link_clk_i,
  input wire logic wp_pin_i,
  input wire wpg_ctl_t ctl_i,
  input wire wpg_wr_t wr_i,
  output logic ack_valid_o,
  output logic ack_o,
  output logic store_valid_o,
  output logic store_ok_o
);

  // ==========================================================
  // Core domain: flag store
  wpg_state_t state_r;
  wpg_flags_t flags_r;
  logic nv_wr_r;
  logic [SYNC_STAGES-1:0] tg_perm_s, tg_rset_s, tg_rclr_s;
  logic seen_perm_r, seen_rset_r, seen_rclr_r;
  logic ev_perm, ev_rset, ev_rclr;
  // Link-side toggles, one per flag command kind
  logic tg_perm_l, tg_rset_l, tg_rclr_l;

  // Toggle is taken once the last two stages agree
  function automatic logic tg_event(input logic [SYNC_STAGES-1:0] s, input logic seen);
    tg_event = (s[1] == s[2]) && (s[2] != seen);
  endfunction

  always_ff @(posedge clk_i) begin
    tg_perm_s <= {tg_perm_s[1:0], tg_perm_l};
    tg_rset_s <= {tg_rset_s[1:0], tg_rset_l};
    tg_rclr_s <= {tg_rclr_s[1:0], tg_rclr_l};
  end

  assign ev_perm = tg_event(tg_perm_s, seen_perm_r);
  assign ev_rset = tg_event(tg_rset_s, seen_rset_r);
  assign ev_rclr = tg_event(tg_rclr_s, seen_rclr_r);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      seen_perm_r <= 1'b0;
      seen_rset_r <= 1'b0;
      seen_rclr_r <= 1'b0;
    end else begin
      if (ev_perm) seen_perm_r <= tg_perm_s[2];
      if (ev_rset) seen_rset_r <= tg_rset_s[2];
      if (ev_rclr) seen_rclr_r <= tg_rclr_s[2];
    end
  end

  // Saved flags are read in the first cycle after reset release in which all three toggle synchronisers read zero
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_r <= WPG_LOAD;
      flags_r <= '{perm: RST_FLAG, rev: RST_FLAG};
      nv_wr_r <= 1'b0;
    end else begin
      nv_wr_r <= 1'b0;
      case (state_r)
        WPG_LOAD: begin
          // Wait until the link side has cleared its toggles, so that a toggle
          // left over from before reset is never taken as a fresh command
          if (tg_perm_s == '0 && tg_rset_s == '0 && tg_rclr_s == '0) begin
            flags_r <= nv_flags_i;
            state_r <= WPG_READY;
          end
        end
        WPG_READY: begin
          // Permanent flag has no clearing command; only reset and the reload from the cells can clear it
          if (ev_perm) begin
            flags_r.perm <= 1'b1;
          end
          // Set wins if a clear lands in the same cycle
          if (ev_rset) begin
            flags_r.rev <= 1'b1;
          end else if (ev_rclr) begin
            flags_r.rev <= 1'b0;
          end
          nv_wr_r <= ev_perm | ev_rset | ev_rclr;
        end
        default: state_r <= WPG_LOAD;
      endcase
    end
  end

  assign nv_flags_o = flags_r;
  assign nv_wr_o = nv_wr_r;
  assign flags_o = flags_r;

  logic ready_r;
  always_ff @(posedge clk_i) begin
    if (reset_i) ready_r <= 1'b0;
    else ready_r <= (state_r == WPG_READY);
  end
  assign ready_o = ready_r;

  // ==========================================================
  // Link domain: synchronisers
  // The serial clock may stop between frames; every value here is a
  // level, so nothing is lost while it stands still.
  logic [SYNC_STAGES-1:0] rst_s, rdy_s, perm_s, rev_s, wp_s;
  logic lrst_r, lrdy_r, lperm_r, lrev_r, lwp_r;

  always_ff @(posedge link_clk_i) begin
    rst_s <= {rst_s[1:0], reset_i};
    rdy_s <= {rdy_s[1:0], ready_r};
    perm_s <= {perm_s[1:0], flags_r.perm};
    rev_s <= {rev_s[1:0], flags_r.rev};
    wp_s <= {wp_s[1:0], wp_pin_i};
  end

  always_ff @(posedge link_clk_i) begin
    if (rst_s[1] == rst_s[2]) lrst_r <= rst_s[2];
    if (rdy_s[1] == rdy_s[2]) lrdy_r <= rdy_s[2];
    if (perm_s[1] == perm_s[2]) lperm_r <= perm_s[2];
    if (rev_s[1] == rev_s[2]) lrev_r <= rev_s[2];
    if (wp_s[1] == wp_s[2]) lwp_r <= wp_s[2];
  end

  // ==========================================================
  // Link domain: command decode
  logic is_array, is_flag, rd;
  logic [2:0] sub;
  logic c_rev_any, c_clr, c_perm;
  logic ack_nxt;

  assign is_array = (ctl_i.ctl[NIB_HI:NIB_LO] == NIB_ARRAY);
  assign is_flag = (ctl_i.ctl[NIB_HI:NIB_LO] == NIB_FLAG);
  assign rd = ctl_i.ctl[RW_BIT];
  assign sub = ctl_i.ctl[3:1];
  assign c_rev_any = is_flag && (sub == SUB_REV_SET);
  assign c_clr = is_flag && (sub == SUB_REV_CLR) && !rd;
  assign c_perm = is_flag && !c_rev_any && (sub != SUB_REV_CLR);

  always_comb begin
    ack_nxt = 1'b0;
    if (is_array) begin
      ack_nxt = 1'b1;
    end else if (c_perm) begin
      ack_nxt = !lperm_r;
    end else if (c_rev_any) begin
      ack_nxt = !lrev_r;
    end else if (c_clr) begin
      ack_nxt = !lperm_r;
    end
  end

  logic ack_valid_r, ack_r;

  // Nothing is acknowledged before the saved flags are loaded
  always_ff @(posedge link_clk_i) begin
    if (lrst_r) begin
      ack_valid_r <= 1'b0;
      ack_r <= 1'b0;
      tg_perm_l <= 1'b0;
      tg_rset_l <= 1'b0;
      tg_rclr_l <= 1'b0;
    end else begin
      ack_valid_r <= ctl_i.valid && lrdy_r;
      ack_r <= ctl_i.valid && lrdy_r && ack_nxt;
      // With the pin high the commands are acked but change nothing
      if (ctl_i.valid && lrdy_r && ack_nxt && !lwp_r && !rd) begin
        if (c_perm) tg_perm_l <= !tg_perm_l;
        if (c_rev_any) tg_rset_l <= !tg_rset_l;
        if (c_clr) tg_rclr_l <= !tg_rclr_l;
      end
    end
  end

  assign ack_valid_o = ack_valid_r;
  assign ack_o = ack_r;

  // ==========================================================
  // Link domain: array store permission
  logic store_valid_r, store_ok_r, sw_prot;
  assign sw_prot = lperm_r | lrev_r;

  always_ff @(posedge link_clk_i) begin
    if (lrst_r) begin
      store_valid_r <= 1'b0;
      store_ok_r <= 1'b0;
    end else begin
      store_valid_r <= wr_i.valid;
      store_ok_r <= wr_i.valid && lrdy_r && !lwp_r
        && (!sw_prot || wr_i.addr[ADDR_HALF_BIT]);
    end
  end

  assign store_valid_o = store_valid_r;
  assign store_ok_o = store_ok_r;

endmodule

// >>> wpg_gate_sva.sv
/* Port checker for wpg_gate.
   Assumes the pin and flags stay steady around each request. */
`timescale 1ns/100ps
module wpg_gate_sva
  import wpg_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic link_clk_i,
  input wire logic wp_pin_i,
  input wire wpg_flags_t flags_o,
  input wire logic ready_o,
  input wire logic nv_wr_o,
  input wire wpg_ctl_t ctl_i,
  input wire wpg_wr_t wr_i,
  input wire logic ack_valid_o,
  input wire logic ack_o,
  input wire logic store_valid_o,
  input wire logic store_ok_o
);
  // ==========================================================
  // Last request, held until its answer is sampled
  logic [7:0] last_ctl_r;
  logic last_hi_r;
  always_ff @(posedge link_clk_i) begin
    if (ctl_i.valid) last_ctl_r <= ctl_i.ctl;
  end
  always_ff @(posedge link_clk_i) begin
    if (wr_i.valid) last_hi_r <= wr_i.addr[7];
  end
  a_array_ack: assert property (@(posedge link_clk_i) disable iff (reset_i)
    ack_valid_o && last_ctl_r[7:4] == 4'h_A |-> ack_o) else $error("array not acked");
  a_perm_noack: assert property (@(posedge link_clk_i) disable iff (reset_i)
    ack_valid_o && flags_o.perm && last_ctl_r[7:4] == 4'h_6 && last_ctl_r[3:1] != 3'h_1
    |-> !ack_o) else $error("acked under permanent flag");
  a_rev_noack: assert property (@(posedge link_clk_i) disable iff (reset_i)
    ack_valid_o && flags_o.rev && last_ctl_r[7:1] == 7'h_31 |-> !ack_o)
    else $error("acked under reversible flag");
  a_query_ack: assert property (@(posedge link_clk_i) disable iff (reset_i)
    ack_valid_o && last_ctl_r[7:4] == 4'h_6 && last_ctl_r[0] && last_ctl_r[3:1] != 3'h_3
    |-> ack_o == (last_ctl_r[3:1] == 3'h_1 ? !flags_o.rev : !flags_o.perm))
    else $error("query answer wrong");
  a_pin_store: assert property (@(posedge link_clk_i) disable iff (reset_i)
    store_valid_o && wp_pin_i && $past(wp_pin_i, 6) |-> !store_ok_o)
    else $error("stored with pin high");
  a_low_store: assert property (@(posedge link_clk_i) disable iff (reset_i)
    store_valid_o && !wp_pin_i && !$past(wp_pin_i, 6)
    |-> store_ok_o == (last_hi_r || !(flags_o.perm || flags_o.rev)))
    else $error("store decision wrong");
  a_perm_sticky: assert property (@(posedge clk_i) disable iff (reset_i)
    flags_o.perm |=> flags_o.perm) else $error("permanent flag cleared");
  a_nv_write: assert property (@(posedge clk_i) disable iff (reset_i)
    $past(ready_o) && $changed(flags_o) |-> nv_wr_o) else $error("flag change not saved");
endmodule
bind wpg_gate wpg_gate_sva u_wpg_gate_sva(.clk_i, .reset_i, .link_clk_i, .wp_pin_i,
  .flags_o, .ready_o, .nv_wr_o, .ctl_i, .wr_i, .ack_valid_o, .ack_o, .store_valid_o,
  .store_ok_o);

// >>> wpg_master.sv
/* Two-wire master model on the link clock.
   Assumes an answer one link cycle after the strobe is taken. */
`timescale 1ns/100ps
module wpg_master
  import wpg_pkg::*;
(
  input wire logic link_clk_i,
  input wire logic ack_valid_i,
  input wire logic ack_i,
  input wire logic store_valid_i,
  input wire logic store_ok_i,
  output wpg_ctl_t ctl_o,
  output wpg_wr_t wr_o
);
  initial begin
    ctl_o = '0;
    wr_o = '0;
  end
  // Released bytes show the inverse, so a stale value is never mistaken for a fresh one
  task automatic xfer(input logic is_wr, input logic [7:0] b, output logic [1:0] ans);
    @(posedge link_clk_i);
    if (is_wr) wr_o <= {1'b1, b};
    else ctl_o <= {1'b1, b};
    @(posedge link_clk_i);
    ctl_o <= {1'b0, ~b};
    wr_o <= {1'b0, ~b};
    // The answer stands for the one link cycle after the taking edge
    #1;
    ans = is_wr ? {store_valid_i, store_ok_i} : {ack_valid_i, ack_i};
    repeat (20) @(posedge link_clk_i);
  endtask
endmodule

// >>> tb.sv
/* Self-checking bench for wpg_gate.
   Assumes the master model and a behavioural flag cell store. */
`timescale 1ns/100ps
module tb;
  import wpg_pkg::*;
  logic clk_i, link_clk_i, reset_i, wp_pin_i, nv_wr_o, ready_o;
  logic ack_valid_o, ack_o, store_valid_o, store_ok_o;
  wpg_flags_t cells, nv_flags_o, flags_o;
  wpg_ctl_t ctl_i;
  wpg_wr_t wr_i;
  logic [1:0] ans;
  int n_fail = 0;
  int total_checks = 0;
  wpg_gate u_wpg_gate(.clk_i, .reset_i, .nv_flags_i(cells), .nv_flags_o, .nv_wr_o, .ready_o,
    .flags_o, .link_clk_i, .wp_pin_i, .ctl_i, .wr_i, .ack_valid_o, .ack_o, .store_valid_o,
    .store_ok_o);
  wpg_master u_wpg_master(.link_clk_i, .ack_valid_i(ack_valid_o), .ack_i(ack_o),
    .store_valid_i(store_valid_o), .store_ok_i(store_ok_o), .ctl_o(ctl_i), .wr_o(wr_i));
  initial begin
    clk_i = 0;
    forever #25 clk_i = ~clk_i;
  end
  initial begin
    link_clk_i = 0;
    #7;
    forever #16 link_clk_i = ~link_clk_i;
  end
  // Cells keep flags across resets, as power loss would
  always @(posedge clk_i) if (nv_wr_o) cells <= nv_flags_o;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] b, input logic a);
    u_wpg_master.xfer(1'b0, b, ans);
    chk(ans, {1'b1, a});
  endtask
  task automatic wr(input logic [7:0] addr, input logic ok);
    u_wpg_master.xfer(1'b1, addr, ans);
    chk(ans, {1'b1, ok});
  endtask
  task automatic pin(input logic v);
    @(posedge clk_i) wp_pin_i <= v;
    repeat (8) @(posedge link_clk_i);
  endtask
  task automatic do_reset();
    @(posedge clk_i) reset_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    for (int i = 0; i < 50 && ready_o !== 1'b1; i++) @(posedge clk_i);
    if (ready_o !== 1'b1) begin
      n_fail++;
      give_verdict();
    end
    repeat (10) @(posedge link_clk_i);
  endtask
  task automatic t_open();
    cmd(8'h_61, 1'b1);
    cmd(8'h_63, 1'b1);
    cmd(8'h_A1, 1'b1);
    wr(8'h_10, 1'b1);
    wr(8'h_FF, 1'b1);
  endtask
  task automatic t_pin_high();
    pin(1'b1);
    wr(8'h_90, 1'b0);
    cmd(8'h_60, 1'b1);
    cmd(8'h_62, 1'b1);
    cmd(8'h_66, 1'b1);
    chk(flags_o, 8'h_00);
    pin(1'b0);
  endtask
  task automatic t_rev();
    cmd(8'h_62, 1'b1);
    chk(flags_o, 8'h_01);
    cmd(8'h_63, 1'b0);
    cmd(8'h_62, 1'b0);
    wr(8'h_7F, 1'b0);
    wr(8'h_80, 1'b1);
    cmd(8'h_66, 1'b1);
    chk(flags_o, 8'h_00);
  endtask
  task automatic t_perm();
    cmd(8'h_60, 1'b1);
    cmd(8'h_61, 1'b0);
    cmd(8'h_60, 1'b0);
    wr(8'h_00, 1'b0);
    do_reset();
    chk(flags_o, 8'h_02);
    cmd(8'h_62, 1'b1);
    cmd(8'h_66, 1'b0);
  endtask
  initial begin
    reset_i = 1'b1;
    wp_pin_i = 1'b0;
    cells = '0;
    do_reset();
    t_open();
    t_pin_high();
    t_rev();
    t_perm();
    give_verdict();
  end
endmodule
